// ---- rtl/tap_pkg.sv ----
// constants, state encoding and helpers shared by the test access port
package tap_pkg;
    // ----------------------------------------------------------------
    // widths and depths
    // ----------------------------------------------------------------
    localparam int IR_W = 4; // instruction register length
    localparam int DR_W = 32; // longest data path (identification)
    localparam int USR_W = 8; // user data word length
    localparam int FIFO_DEPTH = 4; // words buffered toward the core
    localparam int SYNC_STAGES = 2; // flip-flops ahead of the test clock, mode-select and data logic
    // ----------------------------------------------------------------
    // instructions and register contents
    // ----------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1; // loaded on test reset
    localparam logic [IR_W-1:0] IR_USER = 4'h8; // user word path
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf; // one-bit path
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1; // fixed capture pattern
    // arbitrary identification value, lsb set as the scan standard asks
    localparam logic [DR_W-1:0] ID_VALUE = 32'h0a5c_0001;
    localparam logic [DR_W-1:0] DR_ZERO = 32'h0000_0000; // cleared path
    localparam logic [USR_W-1:0] USR_ZERO = 8'h00; // empty user word
    // levels that the pads pull an undriven pin to
    localparam logic TMS_PULL = 1'b1; // pull-up
    localparam logic TDI_PULL = 1'b1; // pull-up
    localparam logic TRST_PULL = 1'b0; // pull-down holds the port in reset
    localparam logic [2:0] ONES_TO_RESET = 3'h5; // tms-high edges to reset
    // ----------------------------------------------------------------
    // controller states, fixed four-bit codes; neighbours differ in up to three bits
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR = 4'hf, RTI = 4'hc, SEL_DR = 4'h7, CAP_DR = 4'h6,
        SH_DR = 4'h2, EX1_DR = 4'h1, PAU_DR = 4'h3, EX2_DR = 4'h0,
        UPD_DR = 4'h5, SEL_IR = 4'h4, CAP_IR = 4'he, SH_IR = 4'ha,
        EX1_IR = 4'h9, PAU_IR = 4'hb, EX2_IR = 4'h8, UPD_IR = 4'hd
    } tap_state_t;

    // msb index of the data path chosen by an instruction
    function automatic int unsigned dr_top(input logic [IR_W-1:0] ir);
        if (ir == IR_IDCODE) begin
            return DR_W - 1;
        end else if (ir == IR_USER) begin
            return USR_W - 1;
        end
        return 0;
    endfunction

    // true in either shift state
    function automatic logic is_shift(input tap_state_t st);
        return (st == SH_DR) || (st == SH_IR);
    endfunction
endpackage

// ---- rtl/word_if.sv ----
// handshake bundle between the port logic and its word buffer
`timescale 1ns/1ns
interface word_if #(parameter int W = 8);
    logic fill_valid; // word offered to the buffer
    logic fill_ready; // buffer has room
    logic [W-1:0] fill_data; // offered word
    logic drain_valid; // buffer holds a word
    logic drain_ready; // consumer takes it
    logic [W-1:0] drain_data; // oldest word
    modport buffer (input fill_valid, fill_data, drain_ready,
                    output fill_ready, drain_valid, drain_data);
    modport user (output fill_valid, fill_data, drain_ready,
                  input fill_ready, drain_valid, drain_data);
endinterface

// ---- rtl/word_fifo.sv ----
// small first-in first-out word buffer
`timescale 1ns/1ns
module word_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    word_if.buffer wb
);
    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    localparam int AW = $clog2(DEPTH); // pointer width
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH); // count when full
    logic [W-1:0] mem [DEPTH]; // word array
    logic [AW-1:0] wr_ff, nxt_wr; // write pointer
    logic [AW-1:0] rd_ff, nxt_rd; // read pointer
    logic [AW:0] cnt_ff, nxt_cnt; // words held
    logic push, pop; // accepted transfers

    // honest flags straight from the count
    assign wb.fill_ready = (cnt_ff != FULL_CNT);
    assign wb.drain_valid = (cnt_ff != '0);
    assign wb.drain_data = mem[rd_ff];
    assign push = wb.fill_valid && wb.fill_ready;
    assign pop = wb.drain_valid && wb.drain_ready;

    // next pointers; wrap by modulo so any depth works
    always_comb begin
        nxt_wr = push ? AW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
        nxt_rd = pop ? AW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
        nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // pointer registers, frozen while ce is low
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else if (ce) begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // array needs no reset: unread slots are never shown as valid
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem[wr_ff] <= wb.fill_data;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
        cnt_ff <= FULL_CNT) else $error("buffer count past depth");
    cov_fifo_full: cover property (@(posedge clk_sys) disable iff (!nrst)
        !wb.fill_ready);
endmodule

// ---- rtl/scan_port.sv ----
// boundary-scan test access port sampled by the system clock
// Operation
// - low test reset clears port asynchronously
// - data and mode-select sampled on rising edge
// - test output changes on falling edges only
// - idle low test clock keeps all state except the pending-word flag, which clears when the buffer takes the word
// - test output high-impedance except while shifting
// - undriven test reset reads low, port reset
// - undriven mode-select and data read high
`timescale 1ns/1ns
module scan_port (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_drv,
    input wire logic tdi_pin,
    input wire logic tdi_drv,
    input wire logic trst_n_pin,
    input wire logic trst_drv,
    output logic tdo_o,
    output logic tdo_oe,
    output logic [tap_pkg::USR_W-1:0] word_data,
    output logic word_valid,
    input wire logic word_ready,
    output logic [3:0] tap_state
);
    // ----------------------------------------------------------------
    // pad pulls
    // ----------------------------------------------------------------
    logic trst_eff, tms_eff, tdi_eff; // pin level after pull
    // an open pin takes the pad pull level
    assign trst_eff = trst_drv ? trst_n_pin : tap_pkg::TRST_PULL;
    assign tms_eff = tms_drv ? tms_pin : tap_pkg::TMS_PULL;
    assign tdi_eff = tdi_drv ? tdi_pin : tap_pkg::TDI_PULL;

    // ----------------------------------------------------------------
    // test reset: asynchronous entry, synchronised release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_ff; // release shifts in ones
    logic tap_rst_n; // port reset, active low
    logic rst_clr_n; // async clear of the port
    assign rst_clr_n = nrst & trst_eff;
    // release is resynchronised so no flop sees a runt reset edge
    always_ff @(posedge clk_sys or negedge rst_clr_n) begin
        if (!rst_clr_n) begin
            rst_sync_ff <= 2'h0;
        end else if (ce) begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign tap_rst_n = rst_sync_ff[1];

    // ----------------------------------------------------------------
    // pin synchronisers and test clock edges
    // ----------------------------------------------------------------
    logic [tap_pkg::SYNC_STAGES-1:0] tck_s, tms_s, tdi_s; // two-stage chains
    logic tck_d_ff; // last synchronised test clock
    logic tck_rise, tck_fall; // one-cycle edge strobes
    logic tms_q, tdi_q; // synchronised mode-select and data
    // first stage feeds only the second
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tck_s <= '0;
            tms_s <= '1;
            tdi_s <= '1;
            tck_d_ff <= 1'b0;
        end else if (ce) begin
            tck_s <= {tck_s[0], tck_pin};
            tms_s <= {tms_s[0], tms_eff};
            tdi_s <= {tdi_s[0], tdi_eff};
            tck_d_ff <= tck_s[1];
        end
    end
    assign tms_q = tms_s[1];
    assign tdi_q = tdi_s[1];
    // same latency on all three keeps data aligned to its clock edge
    assign tck_rise = tck_s[1] && !tck_d_ff;
    assign tck_fall = !tck_s[1] && tck_d_ff;

    // ----------------------------------------------------------------
    // controller, instruction and data paths
    // ----------------------------------------------------------------
    tap_pkg::tap_state_t state_ff, nxt_state; // controller state
    logic [tap_pkg::IR_W-1:0] ir_ff, nxt_ir; // active instruction
    logic [tap_pkg::IR_W-1:0] ir_sh_ff, nxt_ir_sh; // instruction shifter
    logic [tap_pkg::DR_W-1:0] dr_sh_ff, nxt_dr_sh; // data shifter
    logic tdo_ff, nxt_tdo; // output bit
    logic oe_ff, nxt_oe; // output enable
    logic pend_ff, nxt_pend; // word waiting for the buffer
    logic [tap_pkg::USR_W-1:0] pend_data_ff, nxt_pend_data; // that word
    logic push_ok; // buffer takes the pending word
    word_if #(.W(tap_pkg::USR_W)) wbus (); // buffer handshake

    assign push_ok = pend_ff && wbus.fill_ready;

    // state step for one mode-select bit
    function automatic tap_pkg::tap_state_t step(input tap_pkg::tap_state_t s,
                                                 input logic m);
        case (s)
            tap_pkg::TLR: return m ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI: return m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: return m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: return m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR: return m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: return m ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR: return m ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR: return m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::SEL_IR: return m ? tap_pkg::TLR : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: return m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR: return m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: return m ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR: return m ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR: return m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            default: return m ? tap_pkg::SEL_DR : tap_pkg::RTI;
        endcase
    endfunction

    // next values; only the pending flag moves without a test clock edge
    always_comb begin
        nxt_state = state_ff;
        nxt_ir = ir_ff;
        nxt_ir_sh = ir_sh_ff;
        nxt_dr_sh = dr_sh_ff;
        nxt_tdo = tdo_ff;
        nxt_oe = oe_ff;
        nxt_pend = pend_ff && !push_ok;
        nxt_pend_data = pend_data_ff;
        if (tck_rise) begin
            nxt_state = step(state_ff, tms_q);
            case (state_ff)
                tap_pkg::TLR: begin
                    nxt_ir = tap_pkg::IR_IDCODE;
                end
                tap_pkg::CAP_IR: begin
                    nxt_ir_sh = tap_pkg::IR_CAPTURE;
                end
                tap_pkg::SH_IR: begin
                    nxt_ir_sh = {tdi_q, ir_sh_ff[tap_pkg::IR_W-1:1]};
                end
                tap_pkg::UPD_IR: begin
                    nxt_ir = ir_sh_ff;
                end
                tap_pkg::CAP_DR: begin
                    // user path reports whether a word is still waiting
                    if (ir_ff == tap_pkg::IR_IDCODE) begin
                        nxt_dr_sh = tap_pkg::ID_VALUE;
                    end else begin
                        nxt_dr_sh = {tap_pkg::DR_ZERO[tap_pkg::DR_W-1:1], pend_ff};
                    end
                end
                tap_pkg::SH_DR: begin
                    nxt_dr_sh = dr_sh_ff >> 1;
                    nxt_dr_sh[tap_pkg::dr_top(ir_ff)] = tdi_q;
                end
                tap_pkg::UPD_DR: begin
                    // a busy slot refuses the word; set beats the drain
                    if (ir_ff == tap_pkg::IR_USER && (!pend_ff || push_ok)) begin
                        nxt_pend = 1'b1;
                        nxt_pend_data = dr_sh_ff[tap_pkg::USR_W-1:0];
                    end
                end
                default: begin
                    nxt_ir_sh = ir_sh_ff;
                end
            endcase
        end
        if (tck_fall) begin
            // output only turns on while a path is shifting
            nxt_oe = tap_pkg::is_shift(state_ff);
            nxt_tdo = (state_ff == tap_pkg::SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
        end
    end

    // port registers; test reset forces the reset state at once
    always_ff @(posedge clk_sys or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_ff <= tap_pkg::TLR;
            ir_ff <= tap_pkg::IR_IDCODE;
            ir_sh_ff <= tap_pkg::IR_CAPTURE;
            dr_sh_ff <= tap_pkg::DR_ZERO;
            tdo_ff <= 1'b0;
            oe_ff <= 1'b0;
            pend_ff <= 1'b0;
            pend_data_ff <= tap_pkg::USR_ZERO;
        end else if (ce) begin
            state_ff <= nxt_state;
            ir_ff <= nxt_ir;
            ir_sh_ff <= nxt_ir_sh;
            dr_sh_ff <= nxt_dr_sh;
            tdo_ff <= nxt_tdo;
            oe_ff <= nxt_oe;
            pend_ff <= nxt_pend;
            pend_data_ff <= nxt_pend_data;
        end
    end

    // ----------------------------------------------------------------
    // word buffer toward the core
    // ----------------------------------------------------------------
    assign wbus.fill_valid = pend_ff;
    assign wbus.fill_data = pend_data_ff;
    assign wbus.drain_ready = word_ready;
    word_fifo #(.W(tap_pkg::USR_W), .DEPTH(tap_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .wb(wbus.buffer)
    );

    assign word_valid = wbus.drain_valid;
    assign word_data = wbus.drain_data;
    assign tdo_o = tdo_ff;
    assign tdo_oe = oe_ff;
    assign tap_state = state_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [2:0] ones_ff; // consecutive tms-high rising edges
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ones_ff <= 3'h0;
        end else if (ce && tck_rise) begin
            ones_ff <= !tms_q ? 3'h0 :
                       (ones_ff == tap_pkg::ONES_TO_RESET) ? ones_ff : ones_ff + 3'h1;
        end
    end

    chk_reset_state: assert property (@(posedge clk_sys) disable iff (!nrst)
        !tap_rst_n |-> state_ff == tap_pkg::TLR && !oe_ff && !pend_ff)
        else $error("port not reset by test reset");
    chk_rise_sample: assert property (@(posedge clk_sys)
        disable iff (!nrst || !tap_rst_n)
        ce && tck_rise && state_ff == tap_pkg::SH_IR |=>
        ir_sh_ff[tap_pkg::IR_W-1] == $past(tdi_q))
        else $error("data not taken on rising edge");
    chk_fall_only: assert property (@(posedge clk_sys)
        disable iff (!nrst || !tap_rst_n)
        tdo_ff != $past(tdo_ff) |-> $past(tck_fall && ce))
        else $error("output moved off a falling edge");
    chk_idle_hold: assert property (@(posedge clk_sys)
        disable iff (!nrst || !tap_rst_n)
        !$past(tck_rise) && !$past(push_ok) |-> $stable(state_ff) && $stable(dr_sh_ff))
        else $error("state moved without a clock edge");
    chk_oe_drop: assert property (@(posedge clk_sys)
        disable iff (!nrst || !tap_rst_n || !ce)
        oe_ff && !tap_pkg::is_shift(state_ff) |-> ##[1:8] !oe_ff)
        else $error("output left enabled after shifting");
    chk_trst_pull: assert property (@(posedge clk_sys) disable iff (!nrst)
        !trst_drv |=> !tap_rst_n) else $error("open test reset not held low");
    chk_tms_pull: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!tms_drv && !tdi_drv && ce) [*2] |=> tms_q && tdi_q)
        else $error("open inputs not read high");
    chk_five_ones: assert property (@(posedge clk_sys)
        disable iff (!nrst || !tap_rst_n)
        ones_ff == tap_pkg::ONES_TO_RESET |-> state_ff == tap_pkg::TLR)
        else $error("five high mode bits did not reset");
    cov_shift_dr: cover property (@(posedge clk_sys) disable iff (!nrst)
        oe_ff && state_ff == tap_pkg::SH_DR);
    cov_update_ir: cover property (@(posedge clk_sys) disable iff (!nrst)
        tck_rise && state_ff == tap_pkg::UPD_IR);
    cov_word_out: cover property (@(posedge clk_sys) disable iff (!nrst)
        word_valid && word_ready);
endmodule

// ---- test/scan_ctrl_model.sv ----
// behavioural scan test controller driving the link pins
`timescale 1ns/1ns
module scan_ctrl_model (
    output logic tck_pin,
    output logic tms_pin,
    output logic tms_drv,
    output logic tdi_pin,
    output logic tdi_drv,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    // ----------------------------------------------------------------
    // line state
    // ----------------------------------------------------------------
    bit tms_loose; // leave mode-select to its pull-up
    bit tdi_loose; // leave data to its pull-up
    wire tdo_wire; // level on the shared output wire
    assign tdo_wire = tdo_oe ? tdo_o : 1'bz;

    // clock rests low between frames, as on an unused port
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tms_drv = 1'b0;
        tdi_pin = 1'b1;
        tdi_drv = 1'b0;
        tms_loose = 1'b0;
        tdi_loose = 1'b0;
    end

    // ----------------------------------------------------------------
    // one test clock period of 80 ns
    // ----------------------------------------------------------------
    // output read late in the high phase: the answer trails the pin by
    // the device's sync latency but stands until the next fall
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        #3;
        tms_drv = !tms_loose;
        tms_pin = tms_loose ? !tms_pin : tms_v;
        tdi_drv = !tdi_loose;
        tdi_pin = tdi_loose ? !tdi_pin : tdi_v;
        #37 tck_pin = 1'b1;
        #39 tdo_v = tdo_wire;
        #1 tck_pin = 1'b0;
    endtask

    // released lines show no stale level; the pull-up reads high
    task automatic release_lines();
        tms_drv = 1'b0;
        tms_pin = !tms_pin;
        tdi_drv = 1'b0;
        tdi_pin = !tdi_pin;
    endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the scan port and its word buffer
`timescale 1ns/1ns
module testbench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, word_ready = 1'b0;
    logic trst_n_pin = 1'b0, trst_drv = 1'b1;
    logic tck_pin, tms_pin, tms_drv, tdi_pin, tdi_drv, tdo_o, tdo_oe, word_valid;
    logic [7:0] word_data;
    logic [3:0] tap_state;
    logic t; // last sampled output wire
    logic [31:0] d; // shifted-out word
    logic [7:0] words[$]; // words expected from the buffer
    int bad_count = 0, num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    scan_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tck_pin(tck_pin),
        .tms_pin(tms_pin), .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv),
        .trst_n_pin(trst_n_pin), .trst_drv(trst_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
        .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
        .tap_state(tap_state));
    scan_ctrl_model i_ctl (.tck_pin(tck_pin), .tms_pin(tms_pin), .tms_drv(tms_drv),
        .tdi_pin(tdi_pin), .tdi_drv(tdi_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // let the state code catch up with the synchronised clock edge
    task automatic settle();
        repeat (6) @(negedge clk_sys);
    endtask

    // from run-test-idle: capture, shift n bits lsb first, update, idle
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic v;
        dout = 32'h0;
        i_ctl.step(1'b1, 1'b1, v);
        if (ir) begin
            i_ctl.step(1'b1, 1'b1, v);
        end
        i_ctl.step(1'b0, 1'b1, v);
        i_ctl.step(1'b0, 1'b1, v);
        for (int i = 0; i < n; i++) begin
            i_ctl.step(i == n - 1, din[i], v);
            dout[i] = v;
        end
        i_ctl.step(1'b1, 1'b1, v);
        check(v, 1'bz);
        i_ctl.step(1'b0, 1'b1, v);
        i_ctl.release_lines();
    endtask

    // five high mode-select edges from anywhere end in test-logic-reset
    task automatic go_reset();
        repeat (5) i_ctl.step(1'b1, 1'b1, t);
        settle();
        check(tap_state, tap_pkg::TLR);
    endtask

    // expected capture of the user path: only the pending flag
    function automatic logic [31:0] user_cap(input bit pend);
        return {31'h0, pend};
    endfunction

    // ----------------------------------------------------------------
    // watchdog: the sequence needs about 56 us, so 200 us means a hang
    // ----------------------------------------------------------------
    initial begin
        #200_000;
        bad_count++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(28919));
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        settle();
        check(tap_state, tap_pkg::TLR);
        check(tdo_oe, 1'b0);
        trst_n_pin = 1'b1;
        trst_drv = 1'b0; // undriven pin: pull-down keeps the port in reset
        repeat (3) i_ctl.step(1'b0, 1'b0, t);
        settle();
        check(tap_state, tap_pkg::TLR);
        i_ctl.release_lines();
        trst_drv = 1'b1; // release with mode-select pulled high
        settle();
        $display("test reset done");

        i_ctl.step(1'b0, 1'b1, t);
        settle();
        check(tap_state, tap_pkg::RTI);
        scan(1'b0, 32, $urandom, d);
        check(d, tap_pkg::ID_VALUE);
        scan(1'b1, 4, tap_pkg::IR_BYPASS, d);
        check(d, tap_pkg::IR_CAPTURE);
        for (int k = 0; k < 3; k++) begin
            logic [15:0] r;
            r = 16'($urandom);
            scan(1'b0, 16, r, d);
            check(d, {16'h0, r[14:0], 1'b0});
        end
        $display("test paths done");

        i_ctl.step(1'b1, 1'b1, t);
        repeat (3000) @(negedge clk_sys);
        check(tap_state, tap_pkg::SEL_DR);
        for (int k = 0; k < 20; k++) begin
            i_ctl.step(1'($urandom), 1'($urandom), t);
        end
        go_reset();
        // the walk may have loaded user words; empty the buffer first
        word_ready = 1'b1;
        repeat (8) @(negedge clk_sys);
        word_ready = 1'b0;
        check(word_valid, 1'b0);
        $display("test idle and walk done");

        i_ctl.tms_loose = 1'b1;
        i_ctl.tdi_loose = 1'b1;
        for (int k = 0; k < 7; k++) begin
            i_ctl.step(1'($urandom), 1'b0, t);
        end
        settle();
        check(tap_state, tap_pkg::TLR);
        i_ctl.tms_loose = 1'b0;
        i_ctl.step(1'b0, 1'b0, t);
        scan(1'b1, 4, 32'h0, d); // floating data shifts in the one-bit path
        scan(1'b0, 8, 32'h0, d);
        check(d, 32'hfe);
        i_ctl.tdi_loose = 1'b0;
        $display("test pull-ups done");

        // buffer fill with the consumer stalled, then an overrun
        scan(1'b1, 4, tap_pkg::IR_USER, d);
        for (int k = 0; k < 6; k++) begin
            logic [7:0] w;
            w = 8'($urandom);
            if (k == 0) begin
                w = 8'hff;
            end
            scan(1'b0, 8, w, d);
            check(d, user_cap(k == 5));
            if (k < 5) begin
                words.push_back(w);
            end
        end
        check(word_valid, 1'b1);
        @(negedge clk_sys);
        word_ready = 1'b1;
        for (int c = 0; c < 40 && words.size() > 0; c++) begin
            if (word_valid === 1'b1) begin
                check(word_data, words.pop_front());
            end
            @(negedge clk_sys);
        end
        word_ready = 1'b0;
        check(words.size(), 0);
        check(word_valid, 1'b0);
        scan(1'b0, 8, 32'h0, d);
        check(d, user_cap(1'b0));
        $display("test buffer done");

        // test reset in mid-shift
        i_ctl.step(1'b1, 1'b1, t);
        i_ctl.step(1'b0, 1'b1, t);
        i_ctl.step(1'b0, 1'b1, t);
        i_ctl.step(1'b0, 1'b0, t);
        @(negedge clk_sys);
        trst_n_pin = 1'b0;
        for (int c = 0; c < 10 && tap_state !== tap_pkg::TLR; c++) begin
            @(negedge clk_sys);
        end
        check(tap_state, tap_pkg::TLR);
        settle();
        check(tdo_oe, 1'b0);
        i_ctl.release_lines();
        trst_n_pin = 1'b1;
        settle();
        i_ctl.step(1'b0, 1'b1, t);
        scan(1'b0, 32, 32'h0, d);
        check(d, tap_pkg::ID_VALUE);
        $display("test mid-shift reset done");
        give_verdict();
    end
endmodule
